/* logic/timer8_ctrl_flags.sv */
// 8-bit timer/counter with compare outputs, flags and axi4-lite registers
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE1: force strobes act only in non-pwm modes
// RULE2: software writes zero strobes in pwm modes
// RULE3: strobe applies compare action per output mode
// RULE4: forced compare sets no flag, no clear
// RULE5: strobe bits always read back zero
// RULE6: reserved register bits read as zero; control a bits 3:2 are stored and read back as written
// RULE7: clock select stops or picks prescaler tap
// RULE8: codes 110/111 count external falling/rising edge
// RULE9: external pin counts even when output
// RULE10: count write blocks next timer-clock match
// RULE11: compare registers compared with count always
// RULE12: mask bits 2,1,0 enable b, a, overflow
// RULE13: request needs global enable, mask, flag
// RULE14: compare match sets channel flag
// RULE15: flag cleared by vector ack or write one
// RULE16: overflow flag set on counter overflow
// RULE17: overflow point depends on waveform mode
// RULE18: three mode bits choose mode and top
// RULE19: non-pwm output mode: off/toggle/clear/set
// RULE20: counter steps per timer clock, holds when stopped
module timer8_ctrl_flags
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins
  input  wire logic        ext_count_pin,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             wave_en_a,
  output logic             wave_en_b,
  // interrupt requests and vector acknowledges
  input  wire logic        ack_cmp_a,
  input  wire logic        ack_cmp_b,
  input  wire logic        ack_overflow,
  output logic             irq_cmp_a,
  output logic             irq_cmp_b,
  output logic             irq_overflow
);
  import timer8_pkg::*;

  typedef struct packed {
    logic       aw_got;
    logic [4:0] aw_addr;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] control_a;
    logic       mode_bit2;
    logic [2:0] clock_sel;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] mask;
    logic [2:0] flags;
    logic       global_en;
    logic       block_match;
    logic       count_down;
    logic [9:0] prescale;
    logic       pin_last;
    logic       out_a;
    logic       out_b;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decoded helpers
  wave_mode_t mode;
  logic       pwm_mode;
  logic       fast_mode;
  logic       pc_mode;
  logic [7:0] top_val;
  logic       tick;
  logic       match_a;
  logic       match_b;
  logic       ovf_evt;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_ok;
  logic       force_a;
  logic       force_b;
  logic [1:0] om_a;
  logic [1:0] om_b;

  // mode decode and top selection
  always_comb begin
    mode      = wave_mode_t'({st_r.mode_bit2, st_r.control_a[1:0]}); // RULE18
    pc_mode   = (st_r.control_a[1:0] == 2'b01);
    fast_mode = (st_r.control_a[1:0] == 2'b11);
    pwm_mode  = pc_mode | fast_mode;
    top_val   = (mode == WM_CTC || mode == WM_PC_CMP || mode == WM_FAST_CMP) ? st_r.cmp_a : CNT_MAX;
    om_a      = st_r.control_a[POS_OUT_MODE_A +: 2];
    om_b      = st_r.control_a[POS_OUT_MODE_B +: 2];
  end

  // timer clock select
  always_comb begin
    case (st_r.clock_sel) // RULE7
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (st_r.prescale & TAP_DIV8) == TAP_DIV8;
      CS_D64:  tick = (st_r.prescale & TAP_DIV64) == TAP_DIV64;
      CS_D256: tick = (st_r.prescale & TAP_DIV256) == TAP_DIV256;
      CS_D1K:  tick = (st_r.prescale & TAP_DIV1024) == TAP_DIV1024;
      // pin read regardless of its direction
      CS_FALL: tick = st_r.pin_last & ~ext_count_pin; // RULE8 RULE9
      CS_RISE: tick = ~st_r.pin_last & ext_count_pin; // RULE8 RULE9
      default: tick = 1'b0;
    endcase
  end

  // compare and overflow events on a timer clock
  always_comb begin
    match_a = tick & ~st_r.block_match & (st_r.count == st_r.cmp_a); // RULE11 RULE10
    match_b = tick & ~st_r.block_match & (st_r.count == st_r.cmp_b); // RULE11 RULE10
    if (pc_mode) begin
      ovf_evt = tick & (st_r.count == CNT_BOTTOM) & st_r.count_down; // RULE17
    end else if (mode == WM_FAST_CMP) begin
      ovf_evt = tick & (st_r.count == top_val); // RULE17
    end else begin
      ovf_evt = tick & (st_r.count == CNT_MAX); // RULE16 RULE17
    end
  end

  // bus handshake terms
  always_comb begin
    s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
    s_axi_wready  = ~st_r.w_got & ~st_r.bvalid;
    s_axi_arready = ~st_r.rvalid;
    wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    rd_fire = s_axi_arvalid & s_axi_arready;
    wr_ok   = wr_fire & st_r.w_lane0;
    force_a = wr_ok & (st_r.aw_addr == OFS_CONTROL_B) & st_r.w_data[BIT_FORCE_A] & ~pwm_mode; // RULE1
    force_b = wr_ok & (st_r.aw_addr == OFS_CONTROL_B) & st_r.w_data[BIT_FORCE_B] & ~pwm_mode; // RULE1
  end

  // output action for one channel in its mode
  function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic hit,
                                     input logic at_top, input logic pwm, input logic fast,
                                     input logic down, input logic tgl_ok);
    logic res;
    res = cur;
    if (!pwm) begin
      if (hit) begin
        case (om) // RULE19 RULE3
          2'b01:   res = ~cur;
          2'b10:   res = 1'b0;
          2'b11:   res = 1'b1;
          default: res = cur;
        endcase
      end
    end else if (om == 2'b01) begin
      if (hit && tgl_ok) begin
        res = ~cur;
      end
    end else if (om[1]) begin
      if (fast) begin
        if (hit) begin
          res = om[0];
        end else if (at_top) begin
          res = ~om[0];
        end
      end else if (hit) begin
        res = om[0] ^ down;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.prescale = st_r.prescale + 10'h001;
    st_nxt.pin_last = ext_count_pin;
    if (tick) begin
      st_nxt.block_match = 1'b0;
    end
    // counter sequence per mode
    if (tick) begin // RULE20
      if (pc_mode) begin
        if (!st_r.count_down && st_r.count >= top_val) begin
          st_nxt.count_down = 1'b1;
          st_nxt.count = st_r.count - 8'h01;
        end else if (st_r.count_down && st_r.count == CNT_BOTTOM) begin
          st_nxt.count_down = 1'b0;
          st_nxt.count = st_r.count + 8'h01;
        end else begin
          st_nxt.count = st_r.count_down ? st_r.count - 8'h01 : st_r.count + 8'h01;
        end
      end else if ((mode == WM_CTC || mode == WM_FAST_CMP) && st_r.count == top_val) begin
        st_nxt.count = CNT_BOTTOM; // forced compare never reaches here
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    // waveform outputs; forced compare acts like a match
    st_nxt.out_a = wave_next(st_r.out_a, om_a, match_a | force_a, tick & (st_r.count == top_val), // RULE3
                             pwm_mode, fast_mode, st_r.count_down, st_r.mode_bit2);
    st_nxt.out_b = wave_next(st_r.out_b, om_b, match_b | force_b, tick & (st_r.count == top_val), // RULE3
                             pwm_mode, fast_mode, st_r.count_down, 1'b0);
    // flags: clear by ack or write-one, set wins
    if (ack_cmp_a) st_nxt.flags[BIT_CMP_A] = 1'b0; // RULE15
    if (ack_cmp_b) st_nxt.flags[BIT_CMP_B] = 1'b0; // RULE15
    if (ack_overflow) st_nxt.flags[BIT_OVF] = 1'b0; // RULE15
    if (wr_ok && st_r.aw_addr == OFS_IRQ_FLAGS) begin
      st_nxt.flags = st_nxt.flags & ~st_r.w_data[2:0]; // RULE15
    end
    // only real matches and overflows set flags, never forced compares
    if (match_a) st_nxt.flags[BIT_CMP_A] = 1'b1; // RULE14 RULE4
    if (match_b) st_nxt.flags[BIT_CMP_B] = 1'b1; // RULE14 RULE4
    if (ovf_evt) st_nxt.flags[BIT_OVF] = 1'b1; // RULE16
    // address and data capture
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_data  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    // register writes
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      if (wr_ok) begin
        case (st_r.aw_addr)
          OFS_CONTROL_A: st_nxt.control_a = st_r.w_data;
          OFS_CONTROL_B: begin
            st_nxt.mode_bit2 = st_r.w_data[BIT_MODE2];
            st_nxt.clock_sel = st_r.w_data[2:0];
          end
          OFS_COUNT: begin
            st_nxt.count       = st_r.w_data;
            st_nxt.block_match = 1'b1; // RULE10
          end
          OFS_CMP_A:     st_nxt.cmp_a = st_r.w_data;
          OFS_CMP_B:     st_nxt.cmp_b = st_r.w_data;
          OFS_IRQ_MASK:  st_nxt.mask = st_r.w_data[2:0]; // RULE12
          OFS_IRQ_FLAGS: st_nxt.bresp = RESP_OKAY;
          OFS_IRQ_CTRL:  st_nxt.global_en = st_r.w_data[0];
          default:       st_nxt.bresp = RESP_SLVERR;
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // register reads, reserved bits zero except control a bits 3:2
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CONTROL_A: st_nxt.rdata = st_r.control_a;
        OFS_CONTROL_B: st_nxt.rdata = {4'h0, st_r.mode_bit2, st_r.clock_sel}; // RULE5 RULE6
        OFS_COUNT:     st_nxt.rdata = st_r.count;
        OFS_CMP_A:     st_nxt.rdata = st_r.cmp_a;
        OFS_CMP_B:     st_nxt.rdata = st_r.cmp_b;
        OFS_IRQ_MASK:  st_nxt.rdata = {5'h00, st_r.mask}; // RULE6
        OFS_IRQ_FLAGS: st_nxt.rdata = {5'h00, st_r.flags}; // RULE6
        OFS_IRQ_CTRL:  st_nxt.rdata = {7'h00, st_r.global_en};
        default: begin
          st_nxt.rdata = RST_BYTE;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    s_axi_bvalid = st_r.bvalid;
    s_axi_bresp  = st_r.bresp;
    s_axi_rvalid = st_r.rvalid;
    s_axi_rresp  = st_r.rresp;
    s_axi_rdata  = {24'h00_0000, st_r.rdata};
    wave_out_a   = st_r.out_a;
    wave_out_b   = st_r.out_b;
    wave_en_a    = (om_a != 2'b00);
    wave_en_b    = (om_b != 2'b00);
    irq_cmp_a    = st_r.global_en & st_r.mask[BIT_CMP_A] & st_r.flags[BIT_CMP_A]; // RULE13
    irq_cmp_b    = st_r.global_en & st_r.mask[BIT_CMP_B] & st_r.flags[BIT_CMP_B]; // RULE13
    irq_overflow = st_r.global_en & st_r.mask[BIT_OVF] & st_r.flags[BIT_OVF]; // RULE13
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_count_write;
    wr_ok && st_r.aw_addr == OFS_COUNT;
  endsequence
  sequence s_force_a;
    force_a;
  endsequence

  AST_FORCE_PWM: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    wr_ok && st_r.aw_addr == OFS_CONTROL_B && st_r.w_data[BIT_FORCE_A] && pwm_mode && !tick
    |=> $stable(wave_out_a)) else $error("force strobe active in pwm mode");
  AST_FORCE_NOFLAG: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    s_force_a ##0 !match_a |=> !$rose(st_r.flags[BIT_CMP_A])) else $error("forced compare set flag");
  AST_FORCE_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    s_force_a ##0 (om_a == 2'b01) ##0 !match_a |=> wave_out_a != $past(wave_out_a))
    else $error("forced toggle missing");
  AST_CTRLB_READ: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    rd_fire && s_axi_araddr == OFS_CONTROL_B |=> s_axi_rdata[7:4] == 4'h0) else $error("strobe bits read nonzero");
  AST_RSV_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    rd_fire && (s_axi_araddr == OFS_IRQ_MASK || s_axi_araddr == OFS_IRQ_FLAGS) |=> s_axi_rdata[7:3] == 5'h00)
    else $error("reserved bits nonzero");
  AST_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
    st_r.clock_sel == CS_STOP && !$past(wr_fire) ##1 !$past(wr_fire) |-> $stable(st_r.count))
    else $error("counter moved while stopped");
  AST_CNT_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
    s_count_write |=> !match_a && !match_b) else $error("match right after count write");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
    irq_overflow |-> st_r.global_en && st_r.mask[0] && st_r.flags[0]) else $error("spurious overflow request");
  AST_MATCH_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
    match_b |=> st_r.flags[BIT_CMP_B]) else $error("match b did not set flag");
  AST_W1C: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
    wr_ok && st_r.aw_addr == OFS_IRQ_FLAGS && st_r.w_data[0] && !ovf_evt |=> !st_r.flags[0])
    else $error("overflow flag not cleared");
  AST_OVF_MAX: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
    mode == WM_NORMAL && tick && st_r.count == CNT_MAX |=> st_r.flags[0]) else $error("overflow not flagged");
endmodule
`default_nettype wire

/* logic/timer8_pkg.sv */
// constants and types shared by the 8-bit timer block
package timer8_pkg;
  // register byte offsets on the bus
  localparam logic [4:0] OFS_CONTROL_A = 5'h00;
  localparam logic [4:0] OFS_CONTROL_B = 5'h04;
  localparam logic [4:0] OFS_COUNT     = 5'h08;
  localparam logic [4:0] OFS_CMP_A     = 5'h0C;
  localparam logic [4:0] OFS_CMP_B     = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK  = 5'h14;
  localparam logic [4:0] OFS_IRQ_FLAGS = 5'h18;
  localparam logic [4:0] OFS_IRQ_CTRL  = 5'h1C;
  // field positions in control b
  localparam int BIT_FORCE_A = 7;
  localparam int BIT_FORCE_B = 6;
  localparam int BIT_MODE2   = 3;
  // field positions in control a
  localparam int POS_OUT_MODE_A = 6;
  localparam int POS_OUT_MODE_B = 4;
  // flag and mask bit positions
  localparam int BIT_CMP_B = 2;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_OVF   = 0;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // fixed counter values
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // prescaler tap masks (divide by 8, 64, 256, 1024)
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV64   = 10'h03F;
  localparam logic [9:0] TAP_DIV256  = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
  // clock source select codes
  localparam logic [2:0] CS_STOP = 3'b000;
  localparam logic [2:0] CS_DIV1 = 3'b001;
  localparam logic [2:0] CS_DIV8 = 3'b010;
  localparam logic [2:0] CS_D64  = 3'b011;
  localparam logic [2:0] CS_D256 = 3'b100;
  localparam logic [2:0] CS_D1K  = 3'b101;
  localparam logic [2:0] CS_FALL = 3'b110;
  localparam logic [2:0] CS_RISE = 3'b111;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // waveform generation modes
  typedef enum logic [2:0] {
    WM_NORMAL   = 3'b000,
    WM_PC_FIX   = 3'b001,
    WM_CTC      = 3'b010,
    WM_FAST_FIX = 3'b011,
    WM_RSV4     = 3'b100,
    WM_PC_CMP   = 3'b101,
    WM_RSV6     = 3'b110,
    WM_FAST_CMP = 3'b111
  } wave_mode_t;
endpackage

/* sim/cpu_model.sv */
// processor core model that executes timer interrupt vectors
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // vector execution enable from the bench
  input  wire logic ack_en,
  // interrupt requests and vector acknowledges
  input  wire logic irq_cmp_a,
  input  wire logic irq_cmp_b,
  input  wire logic irq_overflow,
  output var logic  ack_cmp_a,
  output var logic  ack_cmp_b,
  output var logic  ack_overflow
);
  // one-cycle acknowledge per taken request, never two back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ack_cmp_a, ack_cmp_b, ack_overflow} <= 3'h0;
    end else begin
      ack_cmp_a    <= ack_en && irq_cmp_a && !ack_cmp_a;
      ack_cmp_b    <= ack_en && irq_cmp_b && !ack_cmp_b;
      ack_overflow <= ack_en && irq_overflow && !ack_overflow;
    end
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// register-level testbench for the 8-bit timer block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import timer8_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic        awready, wready, arready, ext_pin, ack_en, wa, wb, ea, eb;
  logic        ack_a, ack_b, ack_o, irq_a, irq_b, irq_o;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bresp_seen, rresp_seen;
  logic [7:0]  v, o;
  int          fails, comparisons, i;
  int          dv[6] = '{0, 1, 8, 64, 256, 1024};

  timer8_ctrl_flags u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_pin(ext_pin),
    .wave_out_a(wa), .wave_out_b(wb), .wave_en_a(ea), .wave_en_b(eb), .ack_cmp_a(ack_a),
    .ack_cmp_b(ack_b), .ack_overflow(ack_o), .irq_cmp_a(irq_a), .irq_cmp_b(irq_b), .irq_overflow(irq_o));
  cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en), .irq_cmp_a(irq_a), .irq_cmp_b(irq_b),
    .irq_overflow(irq_o), .ack_cmp_a(ack_a), .ack_cmp_b(ack_b), .ack_overflow(ack_o));

  ////////////////////////////////////////////////////////////////
  // clock, verdict and bus tasks
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // write: both channels offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, tr;
    awaddr <= a; wdata <= {24'h0000_00, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk); ta = awvalid && awready; tw = wvalid && wready; tr = bvalid; bresp_seen = bresp;
      @(posedge aclk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
      if (tr) break;
    end
    if (n == 50) begin fails++; end_sim(); end
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int n;
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk); ta = arvalid && arready; tr = rvalid; d = rdata[7:0]; rresp_seen = rresp;
      @(posedge aclk); if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    if (n == 50) begin fails++; end_sim(); end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e, input string nm);
    logic [7:0] g;
    rd(a, g);
    `CHK(nm, e, g)
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin, ack_en} = 8'h00;
    {awaddr, araddr, wdata} = '0;
    w(3);
    aresetn <= 1'b1;
    // reset values and reserved bits
    rc(OFS_IRQ_MASK, 8'h00, "mask_rst");
    wr(OFS_CONTROL_B, 8'hFF);
    rc(OFS_CONTROL_B, 8'h0F, "ctlb_rsv");
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_IRQ_MASK, 8'hFF);
    rc(OFS_IRQ_MASK, 8'h07, "mask_rsv");
    `CHK("bresp", RESP_OKAY, bresp_seen)
    `CHK("rresp", RESP_OKAY, rresp_seen)
    wr(OFS_IRQ_FLAGS, 8'hFF);
    rc(OFS_IRQ_FLAGS, 8'h00, "flag_rsv");
    wr(OFS_COUNT, 8'h05); w(20);
    rc(OFS_COUNT, 8'h05, "stopped");
    // internal clock rates, twenty ticks each
    for (i = 1; i < 6; i++) begin
      wr(OFS_COUNT, 8'h00); wr(OFS_CONTROL_B, i[7:0]); w(dv[i] * 20); wr(OFS_CONTROL_B, 8'h00);
      rd(OFS_COUNT, v);
      `CHK("rate", 1'b1, (v >= 20 && v <= (dv[i] == 1 ? 26 : 21)))
    end
    // external pin, falling then rising edge
    for (i = 6; i < 8; i++) begin
      wr(OFS_COUNT, 8'h00); wr(OFS_CONTROL_B, i[7:0]);
      repeat (5) begin ext_pin <= 1'b1; w(3); ext_pin <= 1'b0; w(3); end
      wr(OFS_CONTROL_B, 8'h00);
      rc(OFS_COUNT, 8'h05, "ext");
    end
    // compare and overflow flags, masking and clearing
    wr(OFS_IRQ_MASK, 8'h00); wr(OFS_CMP_A, 8'h20); wr(OFS_CMP_B, 8'h30); wr(OFS_COUNT, 8'h00);
    wr(OFS_CONTROL_B, 8'h01); w(300); wr(OFS_CONTROL_B, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h07, "flags");
    wr(OFS_IRQ_CTRL, 8'h01);
    @(negedge aclk); `CHK("irq_off", 3'b000, {irq_b, irq_a, irq_o}) @(posedge aclk);
    wr(OFS_IRQ_MASK, 8'h07);
    @(negedge aclk); `CHK("irq_on", 3'b111, {irq_b, irq_a, irq_o}) @(posedge aclk);
    wr(OFS_IRQ_FLAGS, 8'h02);
    rc(OFS_IRQ_FLAGS, 8'h05, "w1c");
    wr(OFS_IRQ_FLAGS, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h05, "w0");
    wr(OFS_IRQ_CTRL, 8'h00);
    @(negedge aclk); `CHK("irq_gie", 3'b000, {irq_b, irq_a, irq_o}) @(posedge aclk);
    wr(OFS_IRQ_CTRL, 8'h01); ack_en <= 1'b1; w(6); ack_en <= 1'b0;
    rc(OFS_IRQ_FLAGS, 8'h00, "vector");
    // forced compare in clear-on-match mode for each output action
    wr(OFS_COUNT, 8'h20);
    for (i = 1; i < 4; i++) begin
      wr(OFS_CONTROL_A, 8'((i << 6) | (i << 4) | 2)); o = {6'h00, wa, wb};
      wr(OFS_CONTROL_B, 8'hC0);
      @(negedge aclk);
      `CHK("force", (i == 1 ? ~o[1:0] : (i == 2 ? 2'b00 : 2'b11)), {wa, wb})
      `CHK("wave_en", 2'b11, {ea, eb}) @(posedge aclk);
    end
    rc(OFS_IRQ_FLAGS, 8'h00, "force_flag");
    rc(OFS_COUNT, 8'h20, "force_cnt");
    wr(OFS_CONTROL_A, 8'h83); wr(OFS_CONTROL_B, 8'h80);
    @(negedge aclk); `CHK("pwm_force", 1'b1, wa) @(posedge aclk);
    // count write hides the following match, a plain run does not
    wr(OFS_CONTROL_A, 8'h00); wr(OFS_CMP_A, 8'h40); wr(OFS_COUNT, 8'h40);
    wr(OFS_CONTROL_B, 8'h01); w(4); wr(OFS_CONTROL_B, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h00, "blocked");
    wr(OFS_COUNT, 8'h3E); wr(OFS_CONTROL_B, 8'h01); w(4); wr(OFS_CONTROL_B, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h02, "match");
    // fast pwm with compare top overflows at top
    wr(OFS_IRQ_FLAGS, 8'h07); wr(OFS_CMP_A, 8'h10); wr(OFS_COUNT, 8'h00); wr(OFS_CONTROL_A, 8'h03);
    wr(OFS_CONTROL_B, 8'h09); w(40); wr(OFS_CONTROL_B, 8'h08);
    rd(OFS_IRQ_FLAGS, v);
    `CHK("top_ovf", 1'b1, v[0])
    rd(OFS_COUNT, v);
    `CHK("top_cnt", 1'b1, (v <= 8'h10))
    // phase-correct pwm overflows at bottom, not at the turn
    wr(OFS_IRQ_FLAGS, 8'h07); wr(OFS_CONTROL_A, 8'h01); wr(OFS_COUNT, 8'hF0);
    wr(OFS_CONTROL_B, 8'h01); w(30); wr(OFS_CONTROL_B, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h00, "pc_turn");
    wr(OFS_CONTROL_B, 8'h01); w(300); wr(OFS_CONTROL_B, 8'h00);
    rc(OFS_IRQ_FLAGS, 8'h07, "pc_bottom");
    end_sim();
  end
endmodule
`default_nettype wire
